/* rtl/xbr_input_route.sv */
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
`include "xbr_params.svh"
module xbr_input_route import xbr_pkg::*; #(
  parameter int NUM_DMA_CH = 3,
  parameter int DMA_SRC_W  = 32
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [31:0]      s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [31:0]      s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire logic [5:0]       pa_pin,
  input  wire logic [7:0]       pb_pin,
  input  wire logic [4:0]       pc_pin,
  input  wire logic             sync_serial_is_master,
  input  wire logic [DMA_SRC_W-1:0] dma_event_src,
  input  wire logic [2:0]       timer_event,
  input  wire logic [3:0]       pwm_event,
  output logic                  serial0_clk_in,
  output logic                  serial0_rx_in,
  output logic                  serial1_clk_in,
  output logic                  serial1_rx_in,
  output logic                  sync_select_in,
  output logic                  sync_clk_in,
  output logic                  routed_serial_data_in,
  output logic                  timer_external_count_in,
  output logic [NUM_DMA_CH-1:0] dma_single_request,
  output logic [NUM_DMA_CH-1:0] dma_burst_request,
  output logic                  conversion_trigger
);

  // ----------------------------------------
  // parameter check
  // ----------------------------------------
  if (NUM_DMA_CH != 3 || DMA_SRC_W != 32) begin : g_bad
    $error("xbr_input_route: only 3 channels of 32 sources supported");
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // pins are asynchronous; the first stage feeds only the second
  logic [18:0] pin_m_q;
  logic [18:0] pin_s_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_m_q <= 19'h0;
      pin_s_q <= 19'h0;
    end else begin
      pin_m_q <= {pc_pin, pb_pin, pa_pin};
      pin_s_q <= pin_m_q;
    end
  end
  wire [5:0] pa = pin_s_q[5:0];
  wire [7:0] pb = pin_s_q[13:6];
  wire [4:0] pc = pin_s_q[18:14];

  // ----------------------------------------
  // bus slave: write path
  // ----------------------------------------
  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        aw_hold_q;
  logic        w_hold_q;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;

  wire aw_fire = s_axi_awvalid & awready_q;
  wire w_fire  = s_axi_wvalid & wready_q;
  wire wr_fire = aw_hold_q & w_hold_q & ~bvalid_q;
  wire b_fire  = bvalid_q & s_axi_bready;
  wire [31:0] wr_addr = {awaddr_q[31:2], 2'b00};

  wire wr_ser0 = wr_fire & (wr_addr == `XBR_ADDR_SER0);
  wire wr_ser1 = wr_fire & (wr_addr == `XBR_ADDR_SER1);
  wire wr_spi  = wr_fire & (wr_addr == `XBR_ADDR_SPI);
  wire wr_dma  = wr_fire & (wr_addr == `XBR_ADDR_DMA);
  wire wr_adc  = wr_fire & (wr_addr == `XBR_ADDR_ADC);
  wire wr_tim0 = wr_fire & (wr_addr == `XBR_ADDR_TIM0);
  wire wr_hit  = wr_ser0 | wr_ser1 | wr_spi | wr_dma | wr_adc | wr_tim0;

  // address and data are taken in either order; ready drops until
  // the response is accepted so only one write is ever in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
    end else begin
      if (aw_fire) begin
        aw_hold_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (w_fire) begin
        w_hold_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_hit ? XBR_OKAY : XBR_SLVERR;
      end
      if (b_fire) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_q <= 32'h0;
      wdata_q  <= 32'h0;
      wstrb_q  <= 4'h0;
    end else begin
      if (aw_fire) awaddr_q <= s_axi_awaddr;
      if (w_fire) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
    end
  end

  // byte lanes turned into a bit mask
  logic [31:0] wr_bmask;
  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign wr_bmask[8*i +: 8] = {8{wstrb_q[i]}};
  end

  function automatic xbr_word_t merge(input xbr_word_t old,
                                     input xbr_word_t keep);
    return ((old & ~wr_bmask) | (wdata_q & wr_bmask)) & keep;
  endfunction

  // ----------------------------------------
  // route registers
  // ----------------------------------------
  xbr_word_t ser0_q;
  xbr_word_t ser1_q;
  xbr_word_t spi_q;
  xbr_word_t dma_q;
  xbr_word_t adc_q;
  xbr_word_t tim0_q;

  // unwritable bits never store, so reserved bits read as zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ser0_q <= `XBR_RST_WORD;
      ser1_q <= `XBR_RST_WORD;
      spi_q  <= `XBR_RST_WORD;
      dma_q  <= `XBR_RST_WORD;
      adc_q  <= `XBR_RST_WORD;
      tim0_q <= `XBR_RST_WORD;
    end else begin
      if (wr_ser0) ser0_q <= merge(ser0_q, `XBR_MASK_SER);
      if (wr_ser1) ser1_q <= merge(ser1_q, `XBR_MASK_SER);
      if (wr_spi)  spi_q  <= merge(spi_q, `XBR_MASK_SPI);
      if (wr_dma)  dma_q  <= merge(dma_q, `XBR_MASK_DMA);
      if (wr_adc)  adc_q  <= merge(adc_q, `XBR_MASK_ADC);
      if (wr_tim0) tim0_q <= merge(tim0_q, `XBR_MASK_TIM);
    end
  end

  // ----------------------------------------
  // bus slave: read path
  // ----------------------------------------
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  wire ar_fire = s_axi_arvalid & arready_q;
  wire r_fire  = rvalid_q & s_axi_rready;
  wire [31:0] rd_addr = {s_axi_araddr[31:2], 2'b00};
  wire rd_ser0 = rd_addr == `XBR_ADDR_SER0;
  wire rd_ser1 = rd_addr == `XBR_ADDR_SER1;
  wire rd_spi  = rd_addr == `XBR_ADDR_SPI;
  wire rd_dma  = rd_addr == `XBR_ADDR_DMA;
  wire rd_adc  = rd_addr == `XBR_ADDR_ADC;
  wire rd_tim0 = rd_addr == `XBR_ADDR_TIM0;
  wire rd_hit  = rd_ser0 | rd_ser1 | rd_spi | rd_dma | rd_adc | rd_tim0;
  wire xbr_word_t rd_word = rd_ser0 ? ser0_q :
                            rd_ser1 ? ser1_q :
                            rd_spi  ? spi_q  :
                            rd_dma  ? dma_q  :
                            rd_adc  ? adc_q  :
                            rd_tim0 ? tim0_q : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= 2'h0;
    end else if (ar_fire) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_word;
      rresp_q   <= rd_hit ? XBR_OKAY : XBR_SLVERR;
    end else if (r_fire) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  // ----------------------------------------
  // serial port input selection
  // ----------------------------------------
  // reserved codes fall through to constant zero
  wire [2:0] s0_clk = ser0_q[4:2];
  wire [1:0] s0_rx  = ser0_q[1:0];
  wire s0_clk_d = (s0_clk == 3'h1) ? pb[1] :
                  (s0_clk == 3'h3) ? pb[7] : 1'b0;
  wire s0_rx_d  = (s0_rx == 2'h1) ? pb[5] :
                  (s0_rx == 2'h2) ? pc[3] : 1'b0;
  wire [2:0] s1_clk = ser1_q[4:2];
  wire [1:0] s1_rx  = ser1_q[1:0];
  wire s1_clk_d = (s1_clk == 3'h1) ? pa[1] :
                  (s1_clk == 3'h3) ? pb[7] :
                  (s1_clk == 3'h4) ? pc[4] : 1'b0;
  wire s1_rx_d  = (s1_rx == 2'h1) ? pa[2] :
                  (s1_rx == 2'h2) ? pb[1] : 1'b0;

  // ----------------------------------------
  // sync serial input selection
  // ----------------------------------------
  wire [2:0] spi_code = spi_q[2:0];
  wire spi_pa = spi_code == XBR_SPI_PB_A;
  wire spi_pb = spi_code == XBR_SPI_PB_B;
  wire spi_pc = spi_code == XBR_SPI_PC;
  wire spi_sel_pin = spi_pa ? pb[2] :
                     spi_pb ? pb[5] :
                     spi_pc ? pc[1] : 1'b1;
  wire spi_clk_pin = spi_pa ? pb[3] :
                     spi_pb ? pb[6] :
                     spi_pc ? pc[0] : 1'b0;
  wire spi_dat_d   = spi_pa ? pb[0] :
                     spi_pb ? pb[4] :
                     spi_pc ? pc[3] : 1'b0;
  // a master drives its own select and clock; pins are ignored then
  wire spi_sel_d = sync_serial_is_master ? 1'b1 : spi_sel_pin;
  wire spi_clk_d = sync_serial_is_master ? 1'b0 : spi_clk_pin;

  // ----------------------------------------
  // timer 0 count input
  // ----------------------------------------
  wire [1:0] t0_code = tim0_q[1:0];
  wire t0_d = (t0_code == 2'h1) ? pa[1] :
              (t0_code == 2'h2) ? pb[1] :
              (t0_code == 2'h3) ? pc[1] : 1'b0;

  // ----------------------------------------
  // dma trigger selection
  // ----------------------------------------
  logic [NUM_DMA_CH-1:0] dma_single_d;
  logic [NUM_DMA_CH-1:0] dma_burst_d;
  for (genvar c = 0; c < NUM_DMA_CH; c++) begin : g_dma
    wire [4:0] sel  = dma_q[c*`XBR_DMA_STRIDE +: 5];
    wire       kind = dma_q[c*`XBR_DMA_STRIDE + `XBR_DMA_KIND_BIT];
    // code n picks event source bit n; zero and reserved codes are dead
    wire live = (sel != 5'h0) && (sel != `XBR_DMA_RSVD) &&
                (sel <= `XBR_DMA_LAST_SRC);
    wire ev   = live & dma_event_src[sel];
    assign dma_single_d[c] = ev & ~kind;
    assign dma_burst_d[c]  = ev & kind;
  end

  // ----------------------------------------
  // adc trigger selection
  // ----------------------------------------
  // switching here can glitch; software gates the adc's own enable
  wire [7:0] adc_pin = adc_q[15:8];
  wire [7:0] adc_tim = adc_q[7:0];
  wire adc_pin_d = (adc_pin == 8'h1) ? pb[0] :
                   (adc_pin == 8'h2) ? pc[0] :
                   (adc_pin == 8'h3) ? pc[4] : 1'b0;
  wire adc_tim_ok = (adc_tim < `XBR_ADC_TIM_RSVD) ||
                    ((adc_tim > `XBR_ADC_TIM_RSVD) &&
                     (adc_tim <= `XBR_ADC_TIM_LAST));
  wire [7:0] adc_tim_src = {pwm_event, 1'b0, timer_event};
  wire adc_tim_d = adc_tim_ok & adc_tim_src[adc_tim[2:0]];
  wire adc_d = adc_q[`XBR_ADC_KIND_BIT] ? adc_tim_d : adc_pin_d;

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  // one cycle of latency buys glitch-free outputs to the peripherals
  logic [7:0]            route_q;
  logic [NUM_DMA_CH-1:0] dma_single_q;
  logic [NUM_DMA_CH-1:0] dma_burst_q;
  logic                  adc_trig_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      route_q      <= 8'h10;
      dma_single_q <= '0;
      dma_burst_q  <= '0;
      adc_trig_q   <= 1'b0;
    end else begin
      route_q <= {t0_d, spi_dat_d, spi_clk_d, spi_sel_d,
                  s1_rx_d, s1_clk_d, s0_rx_d, s0_clk_d};
      dma_single_q <= dma_single_d;
      dma_burst_q  <= dma_burst_d;
      adc_trig_q   <= adc_d;
    end
  end

  assign serial0_clk_in          = route_q[0];
  assign serial0_rx_in           = route_q[1];
  assign serial1_clk_in          = route_q[2];
  assign serial1_rx_in           = route_q[3];
  assign sync_select_in          = route_q[4];
  assign sync_clk_in             = route_q[5];
  assign routed_serial_data_in   = route_q[6];
  assign timer_external_count_in = route_q[7];
  assign dma_single_request      = dma_single_q;
  assign dma_burst_request       = dma_burst_q;
  assign conversion_trigger      = adc_trig_q;
  assign s_axi_awready           = awready_q;
  assign s_axi_wready            = wready_q;
  assign s_axi_bvalid            = bvalid_q;
  assign s_axi_bresp             = bresp_q;
  assign s_axi_arready           = arready_q;
  assign s_axi_rvalid            = rvalid_q;
  assign s_axi_rdata             = rdata_q;
  assign s_axi_rresp             = rresp_q;

endmodule

/* rtl/xbr_params.svh */
`ifndef XBR_PARAMS_SVH
`define XBR_PARAMS_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define XBR_ADDR_SER0 32'h40500020
`define XBR_ADDR_SER1 32'h40500024
`define XBR_ADDR_SPI  32'h40500028
`define XBR_ADDR_DMA  32'h40500030
`define XBR_ADDR_ADC  32'h40500034
`define XBR_ADDR_TIM0 32'h40500038

// ----------------------------------------
// writable bits and reset values
// ----------------------------------------
`define XBR_MASK_SER  32'h0000001f
`define XBR_MASK_SPI  32'h00000007
`define XBR_MASK_DMA  32'h003f3f3f
`define XBR_MASK_ADC  32'h0001ffff
`define XBR_MASK_TIM  32'h00000003
`define XBR_RST_WORD  32'h00000000

// ----------------------------------------
// field positions
// ----------------------------------------
`define XBR_SER_CLK_LSB  2
`define XBR_DMA_STRIDE   8
`define XBR_DMA_KIND_BIT 5
`define XBR_ADC_KIND_BIT 16
`define XBR_ADC_PIN_LSB  8

// ----------------------------------------
// selector codes
// ----------------------------------------
`define XBR_DMA_LAST_SRC 5'h1b
`define XBR_DMA_RSVD     5'h02
`define XBR_ADC_TIM_RSVD 8'h03
`define XBR_ADC_TIM_LAST 8'h07
`endif

/* rtl/xbr_pkg.sv */
package xbr_pkg;
  typedef logic [31:0] xbr_word_t;
  typedef enum logic [1:0] {
    XBR_OKAY   = 2'h0,
    XBR_SLVERR = 2'h2
  } xbr_resp_e;
  typedef enum logic [2:0] {
    XBR_SPI_IDLE = 3'h0,
    XBR_SPI_NA   = 3'h1,
    XBR_SPI_PB_A = 3'h2,
    XBR_SPI_PB_B = 3'h3,
    XBR_SPI_PC   = 3'h4
  } xbr_spi_route_e;
endpackage

/* verif/crossbar_input_trigger_routing_tb.sv */
`timescale 1ns/1ps
`include "xbr_params.svh"
module crossbar_input_trigger_routing_tb;
  import xbr_pkg::*;
  logic        aclk = 0;
  logic        aresetn = 0;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [5:0]  pa_pin = 0;
  logic [7:0]  pb_pin = 0;
  logic [4:0]  pc_pin = 0;
  logic        sync_serial_is_master = 0, hw_trig_en = 0;
  logic [38:0] ev = 0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire         s_axi_rvalid, sync_select_in, sync_clk_in;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata, dma_event_src;
  wire  [2:0]  timer_event, dma_single_request, dma_burst_request;
  wire  [3:0]  pwm_event;
  wire         serial0_clk_in, serial0_rx_in, serial1_clk_in, serial1_rx_in;
  wire         routed_serial_data_in, timer_external_count_in;
  wire         conversion_trigger;
  wire         conv_start;
  wire  [7:0]  routed = {serial0_clk_in, serial0_rx_in, serial1_clk_in,
                         serial1_rx_in, sync_select_in, sync_clk_in,
                         routed_serial_data_in, timer_external_count_in};
  integer      seed = 32'h0d2a923d;
  int          errors = 0, checked = 0;
  logic [31:0] addr [6] = '{`XBR_ADDR_SER0, `XBR_ADDR_SER1, `XBR_ADDR_SPI,
                            `XBR_ADDR_DMA, `XBR_ADDR_ADC, `XBR_ADDR_TIM0};
  logic [31:0] mask [6] = '{32'h1f, 32'h1f, 32'h7, 32'h3f3f3f, 32'h1ffff,
                            32'h3};
  always #2 aclk = ~aclk;
  xbr_input_route uut (.*);
  xbr_periph_model peer (.aclk(aclk), .ev_d(ev),
    .converter_hw_trigger_enable(hw_trig_en),
    .conversion_trigger(conversion_trigger), .dma_event_src(dma_event_src),
    .timer_event(timer_event), .pwm_event(pwm_event),
    .conv_start_q(conv_start));
  // ----------------------------------------
  // checks and bus cycles
  // ----------------------------------------
  task automatic chk(input logic [33:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!s_axi_wready);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, output logic [33:0] q);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    q = {s_axi_rresp, s_axi_rdata};
    s_axi_rready <= 1'b0;
  endtask
  // ----------------------------------------
  // expected values
  // ----------------------------------------
  function automatic logic [7:0] route(input logic [4:0] c0, c1,
                                       input logic [2:0] sp,
                                       input logic [1:0] t);
    logic [7:0] v;
    v[7] = (c0[4:2] == 3'h1) & pb_pin[1] | (c0[4:2] == 3'h3) & pb_pin[7];
    v[6] = (c0[1:0] == 2'h1) & pb_pin[5] | (c0[1:0] == 2'h2) & pc_pin[3];
    v[5] = (c1[4:2] == 3'h1) & pa_pin[1] | (c1[4:2] == 3'h3) & pb_pin[7]
         | (c1[4:2] == 3'h4) & pc_pin[4];
    v[4] = (c1[1:0] == 2'h1) & pa_pin[2] | (c1[1:0] == 2'h2) & pb_pin[1];
    case (sp)
      3'h2: v[3:1] = {pb_pin[2], pb_pin[3], pb_pin[0]};
      3'h3: v[3:1] = {pb_pin[5], pb_pin[6], pb_pin[4]};
      3'h4: v[3:1] = {pc_pin[1], pc_pin[0], pc_pin[3]};
      default: v[3:1] = 3'h4;
    endcase
    if (sync_serial_is_master) v[3:2] = 2'h2;
    v[0] = (t == 2'h1) & pa_pin[1] | (t == 2'h2) & pb_pin[1]
         | (t == 2'h3) & pc_pin[1];
    return v;
  endfunction
  function automatic logic dma_hit(input logic [4:0] c);
    return (c == 5'h01 || c > 5'h02 && c < 5'h1c) & ev[7 + c];
  endfunction
  function automatic logic adc_exp(input logic [16:0] f);
    if (f[16])
      return f[7:0] < 8'h03 ? ev[4 + f[7:0]] :
        (f[7:0] > 8'h03 && f[7:0] < 8'h08) & ev[f[7:0] - 8'h04];
    return (f[15:8] == 8'h01) & pb_pin[0] | (f[15:8] == 8'h02) & pc_pin[0]
         | (f[15:8] == 8'h03) & pc_pin[4];
  endfunction
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    logic [33:0] q;
    logic [1:0]  r;
    logic [31:0] f [6];
    logic [4:0]  dc [3];
    logic [2:0]  se, be;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(34'(routed), 34'h08);
    chk(34'({dma_single_request, dma_burst_request,
             conversion_trigger}), 34'h0);
    for (int k = 0; k < 6; k++) begin
      rd(addr[k], q);
      chk(q, 34'h0);
    end
    $display("reset test done");
    wr(32'h4050002c, 32'hffffffff, r);
    chk(34'(r), 34'h2);
    rd(32'h4050003c, q);
    chk(q, {2'h2, 32'h0});
    $display("unmapped test done");
    for (int i = 0; i < 40; i++) begin
      dc[0] = 5'(i);
      dc[1] = 5'(i + 11);
      dc[2] = 5'(i + 22);
      f[0] = 32'(i[4:0]);
      f[1] = 32'(~i[4:0]);
      f[2] = 32'(i[2:0]);
      f[3] = {10'h0, i[2], dc[2], 2'h0, i[1], dc[1], 2'h0, i[0], dc[0]};
      f[4] = {15'h0, i[0], 5'h0, i[3:1], 4'h0, i[4:1]};
      f[5] = 32'(i[1:0]);
      // converter trigger held off while its selection changes
      hw_trig_en <= 1'b0;
      for (int k = 0; k < 6; k++) begin
        f[k] = 32'($random(seed)) & ~mask[k] | f[k];
        wr(addr[k], f[k], r);
        chk(34'(r), 34'h0);
      end
      // routed pins are driven by nothing but this bench
      pa_pin <= 6'($random(seed));
      pb_pin <= 8'($random(seed));
      pc_pin <= 5'($random(seed));
      sync_serial_is_master <= 1'($random(seed));
      ev <= {$random(seed), 7'($random(seed))};
      repeat (6) @(posedge aclk);
      hw_trig_en <= 1'b1;
      chk(34'(conv_start), 34'h0);
      chk(34'(routed), 34'(route(f[0][4:0], f[1][4:0], f[2][2:0], f[5][1:0])));
      for (int k = 0; k < 3; k++) begin
        se[k] = !i[k] & dma_hit(dc[k]);
        be[k] = i[k] & dma_hit(dc[k]);
      end
      chk(34'({dma_single_request, dma_burst_request}), 34'({se, be}));
      chk(34'(conversion_trigger), 34'(adc_exp(f[4][16:0])));
      for (int k = 0; k < 6; k++) begin
        rd(addr[k], q);
        chk(q, {2'h0, f[k] & mask[k]});
      end
      // enabled converter starts on the selected trigger only
      chk(34'(conv_start), 34'(adc_exp(f[4][16:0])));
    end
    $display("routing test done");
    // one byte lane only: the other selector bytes must stay put
    s_axi_wstrb <= 4'h2;
    wr(`XBR_ADDR_DMA, 32'hffffffff, r);
    s_axi_wstrb <= 4'hf;
    chk(34'(r), 34'h0);
    rd(`XBR_ADDR_DMA, q);
    chk(q, {2'h0, f[3] & 32'h003f003f | 32'h00003f00});
    $display("byte lane test done");
    end_of_test();
  end
  // about ten times the expected run length
  initial begin
    #100000;
    errors++;
    end_of_test();
  end
endmodule

/* verif/xbr_input_route_sva.sv */
`timescale 1ns/1ps
module xbr_input_route_sva import xbr_pkg::*; #(
  parameter int NUM_DMA_CH = 3
) (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic                  sync_serial_is_master,
  input wire logic                  sync_select_in,
  input wire logic                  sync_clk_in,
  input wire logic [NUM_DMA_CH-1:0] dma_single_request,
  input wire logic [NUM_DMA_CH-1:0] dma_burst_request,
  input wire logic                  conversion_trigger
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // bus handshakes
  // ----------------------------------------
  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  wr_answer_a: assert property (aw_w_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  wr_done_a: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not reopened");
  rd_answer_a: assert property (ar_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  rd_done_a: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid && s_axi_arready)
    else $error("read channel not reopened");
  // ----------------------------------------
  // routed outputs
  // ----------------------------------------
  idle_reset_a: assert property ($rose(aresetn) |-> sync_select_in &&
    !sync_clk_in && !conversion_trigger && dma_single_request == '0 &&
    dma_burst_request == '0)
    else $error("outputs not idle after reset");
  master_mode_a: assert property ($past(sync_serial_is_master) |->
    sync_select_in && !sync_clk_in)
    else $error("slave inputs active in master mode");
  dma_kind_a: assert property ((dma_single_request & dma_burst_request) == '0)
    else $error("single and burst request together");
endmodule
bind xbr_input_route xbr_input_route_sva #(.NUM_DMA_CH(NUM_DMA_CH)) u_sva (.*);

/* verif/xbr_periph_model.sv */
`timescale 1ns/1ps
module xbr_periph_model import xbr_pkg::*; (
  input  wire logic        aclk,
  input  wire logic [38:0] ev_d,
  input  wire logic        converter_hw_trigger_enable,
  input  wire logic        conversion_trigger,
  output logic      [31:0] dma_event_src,
  output logic      [2:0]  timer_event,
  output logic      [3:0]  pwm_event,
  output logic             conv_start_q
);
  // ----------------------------------------
  // event sources
  // ----------------------------------------
  // peripherals hold event levels for whole cycles of the same clock
  always_ff @(posedge aclk) begin
    {dma_event_src, timer_event, pwm_event} <= ev_d;
  end
  // converter starts only while software leaves the trigger enabled
  always_ff @(posedge aclk) begin
    conv_start_q <= converter_hw_trigger_enable & conversion_trigger;
  end
endmodule
